// ---- hdl/sram_port_defs.vh ----
/*
 * constants of the synchronous burst sram port: widths, burst orders,
 * pipeline depth and the fifo depth of the write-data path.
 * assumes it is included by its bare name from the design files.
 */
`ifndef SRAM_PORT_DEFS_VH
`define SRAM_PORT_DEFS_VH
// ----------------------------------------
// geometry
// ----------------------------------------
`define SP_LANES 4
`define SP_LANE_W 8
`define SP_ADDR_W 10
`define SP_PIPE_DEPTH 2
`define SP_FIFO_DEPTH 16
`define SP_FIFO_AW 4
// ----------------------------------------
// burst order and cycle kinds
// ----------------------------------------
`define SP_ORDER_LINEAR 1'h0
`define SP_ORDER_INTERLEAVED 1'h1
`define SP_CYC_IDLE 2'h0
`define SP_CYC_READ 2'h1
`define SP_CYC_WRITE 2'h2
`endif

// ---- hdl/sync_fifo.v ----
/*
 * synchronous fifo with valid/ready on both sides, flip-flop storage.
 * assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module sync_fifo #(
	parameter WIDTH = 36,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire arst_n,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0] count_ff;
	wire push;
	wire pop;

	// honest full and empty
	assign in_ready = (count_ff != DEPTH[AW:0]);
	assign out_valid = (count_ff != {(AW+1){1'b0}});
	assign out_data = mem_ff[rd_ptr_ff];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// storage write
	always @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	// pointers and level
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule // sync_fifo

// ---- hdl/in_sync3.v ----
/*
 * three-stage synchroniser for pin levels; output changes once
 * the second and third stages agree.
 * assumes an active-low asynchronous reset and a reset value.
 */
`timescale 1ns/1ps
module in_sync3 #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input wire clk,
	input wire arst_n,
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] s1_ff;
	reg [W-1:0] s2_ff;
	reg [W-1:0] s3_ff;
	reg [W-1:0] q_ff;
	integer i;

	// chain and agreement filter
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_ff <= INIT;
			s2_ff <= INIT;
			s3_ff <= INIT;
			q_ff <= INIT;
		end else begin
			s1_ff <= d;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			for (i = 0; i < W; i = i + 1) begin
				if (s2_ff[i] == s3_ff[i]) begin
					q_ff[i] <= s3_ff[i];
				end
			end
		end
	end
	assign q = q_ff;
endmodule // in_sync3

// ---- hdl/sync_burst_sram_port.v ----
/*
 * device-side control of a pipelined synchronous burst sram with no
 * turnaround cycles: address/command capture, 2-bit burst counter,
 * byte-lane writes with parity, stall, sleep and output gating.
 * timing, counted in edges that are neither stalled nor asleep:
 * edge n takes the address and command, edge n+1 reads the array
 * for a read, edge n+2 puts the word on the pins or takes the write
 * data. the write reaches the array one edge after that, so reads
 * in between are served by forwarding from the write path.
 * the write fifo drains one word per edge; the read forward looks
 * at its head only, which suffices while it never holds two words.
 * assumes the controller drives pins synchronous to clk; the output
 * enable and sleep request are asynchronous and are synchronised here.
 * write data is staged through a 16-word fifo into the array.
 */
`timescale 1ns/1ps
`include "sram_port_defs.vh"
module sync_burst_sram_port #(
	parameter ADDR_W = `SP_ADDR_W,
	parameter LANE_W = `SP_LANE_W,
	parameter PARITY = 1
) (
	input wire clk,
	input wire arst_n,
	input wire [ADDR_W-3:0] addr_upper,
	input wire addr_lsb0,
	input wire addr_lsb1,
	input wire chip_select_n,
	input wire chip_select_b_n,
	input wire chip_select_hi,
	input wire load_or_advance_n,
	input wire read_write_n,
	input wire stall_n_enable,
	input wire burst_order_sel,
	input wire output_enable_n,
	input wire sleep_request,
	input wire lane_a_wr_n,
	input wire lane_b_wr_n,
	input wire lane_c_wr_n,
	input wire lane_d_wr_n,
	input wire [LANE_W-1:0] lane_a_data_in,
	input wire [LANE_W-1:0] lane_b_data_in,
	input wire [LANE_W-1:0] lane_c_data_in,
	input wire [LANE_W-1:0] lane_d_data_in,
	input wire [3:0] lane_parity_in,
	output reg [4*LANE_W-1:0] lane_data_out,
	output reg [3:0] lane_parity_out,
	output reg lane_data_oe,
	output reg sleeping,
	output reg write_stall
);
	localparam LW = LANE_W + 1;
	localparam WORD_W = 4 * LW;
	localparam DEPTH = 1 << ADDR_W;
	localparam FIFO_W = WORD_W + 4 + ADDR_W;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// next burst offset for both orders
	function [1:0] burst_offset;
		input [1:0] start;
		input [1:0] count;
		input order;
		begin
			if (order == `SP_ORDER_LINEAR) begin
				burst_offset = start + count;
			end else begin
				burst_offset = start ^ count;
			end
		end
	endfunction

	// lane merge under active-low enables
	function [WORD_W-1:0] merge_lanes;
		input [WORD_W-1:0] old_word;
		input [WORD_W-1:0] new_word;
		input [3:0] wr_n;
		integer k;
		begin
			merge_lanes = old_word;
			for (k = 0; k < 4; k = k + 1) begin
				if (!wr_n[k]) begin
					merge_lanes[k*LW +: LW] = new_word[k*LW +: LW];
				end
			end
		end
	endfunction

	// ----------------------------------------
	// synchronised asynchronous pins
	// ----------------------------------------
	wire oe_n_s;
	wire sleep_s;
	in_sync3 #(.W(2), .INIT(2'b11)) u_async_sync (
		.clk(clk),
		.arst_n(arst_n),
		.d({output_enable_n, sleep_request}),
		.q({oe_n_s, sleep_s})
	);

	// ----------------------------------------
	// array and state
	// ----------------------------------------
	reg [WORD_W-1:0] array_ff [0:DEPTH-1];
	reg [ADDR_W-3:0] base_ff;
	reg [1:0] start_ff;
	reg [1:0] count_ff;
	reg [1:0] cyc_ff;
	reg [3:0] be_ff;
	reg order_ff;
	reg [1:0] p_cyc_ff [0:1];
	reg [ADDR_W-1:0] p_addr_ff [0:1];
	reg [3:0] p_be_ff [0:1];
	reg [WORD_W-1:0] rd_word_ff;
	reg [1:0] nxt_cyc;
	reg [1:0] nxt_count;
	reg [ADDR_W-1:0] cur_addr;
	reg cur_valid;
	wire go;
	wire selected;
	reg [WORD_W-1:0] wr_word;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [FIFO_W-1:0] fifo_out;
	wire wr_push;

	// an edge counts only when not stalled and not asleep
	assign go = !stall_n_enable && !sleep_s;
	assign selected = !chip_select_n && !chip_select_b_n && chip_select_hi;

	// cycle decode for this edge
	always @* begin
		nxt_cyc = cyc_ff;
		nxt_count = count_ff;
		cur_addr = {base_ff, burst_offset(start_ff, count_ff, order_ff)};
		cur_valid = 1'b0;
		if (!load_or_advance_n) begin
			nxt_count = 2'h0;
			cur_addr = {addr_upper, addr_lsb1, addr_lsb0};
			if (!selected) begin
				nxt_cyc = `SP_CYC_IDLE;
			end else if (read_write_n) begin
				nxt_cyc = `SP_CYC_READ;
			end else begin
				nxt_cyc = `SP_CYC_WRITE;
			end
			cur_valid = selected;
		end else begin
			// type held from the load; idle stays idle
			nxt_count = count_ff + 2'h1;
			cur_addr = {base_ff, burst_offset(start_ff, count_ff + 2'h1, order_ff)};
			cur_valid = (cyc_ff != `SP_CYC_IDLE);
		end
	end

	// address/command capture, burst state
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			base_ff <= {(ADDR_W-2){1'b0}};
			start_ff <= 2'h0;
			count_ff <= 2'h0;
			cyc_ff <= `SP_CYC_IDLE;
			be_ff <= 4'hf;
			order_ff <= `SP_ORDER_INTERLEAVED;
			p_cyc_ff[0] <= `SP_CYC_IDLE;
			p_cyc_ff[1] <= `SP_CYC_IDLE;
			p_addr_ff[0] <= {ADDR_W{1'b0}};
			p_addr_ff[1] <= {ADDR_W{1'b0}};
			p_be_ff[0] <= 4'hf;
			p_be_ff[1] <= 4'hf;
		end else if (go) begin
			order_ff <= burst_order_sel;
			cyc_ff <= nxt_cyc;
			count_ff <= nxt_count;
			if (!load_or_advance_n) begin
				base_ff <= addr_upper;
				start_ff <= {addr_lsb1, addr_lsb0};
				be_ff <= {lane_d_wr_n, lane_c_wr_n, lane_b_wr_n, lane_a_wr_n};
			end
			// two-stage pipe from address to data
			p_cyc_ff[0] <= cur_valid ? nxt_cyc : `SP_CYC_IDLE;
			p_addr_ff[0] <= cur_addr;
			p_be_ff[0] <= !load_or_advance_n ? {lane_d_wr_n, lane_c_wr_n, lane_b_wr_n, lane_a_wr_n} : be_ff;
			p_cyc_ff[1] <= p_cyc_ff[0];
			p_addr_ff[1] <= p_addr_ff[0];
			p_be_ff[1] <= p_be_ff[0];
		end
	end

	// ----------------------------------------
	// write data path through the fifo
	// ----------------------------------------
	// lanes packed as parity bit above data byte; parity bits stay
	// zero in the width without parity
	always @* begin
		wr_word = {WORD_W{1'b0}};
		wr_word[0*LW +: LANE_W] = lane_a_data_in;
		wr_word[1*LW +: LANE_W] = lane_b_data_in;
		wr_word[2*LW +: LANE_W] = lane_c_data_in;
		wr_word[3*LW +: LANE_W] = lane_d_data_in;
		if (PARITY != 0) begin
			wr_word[0*LW+LANE_W] = lane_parity_in[0];
			wr_word[1*LW+LANE_W] = lane_parity_in[1];
			wr_word[2*LW+LANE_W] = lane_parity_in[2];
			wr_word[3*LW+LANE_W] = lane_parity_in[3];
		end
	end
	// no push on a stalled edge or all-high enables
	assign wr_push = go && (p_cyc_ff[1] == `SP_CYC_WRITE) && (p_be_ff[1] != 4'hf);

	sync_fifo #(.WIDTH(FIFO_W), .DEPTH(`SP_FIFO_DEPTH), .AW(`SP_FIFO_AW)) u_wr_fifo (
		.clk(clk),
		.arst_n(arst_n),
		.in_valid(wr_push),
		.in_ready(fifo_in_ready),
		.in_data({p_addr_ff[1], p_be_ff[1], wr_word}),
		.out_valid(fifo_out_valid),
		.out_ready(!sleep_s),
		.out_data(fifo_out)
	);

	// ----------------------------------------
	// fifo head and read forwarding
	// ----------------------------------------
	// fields of the fifo head
	wire [ADDR_W-1:0] head_addr;
	wire [3:0] head_be;
	wire [WORD_W-1:0] head_word;
	reg [3:0] fwd_head_be;
	reg [3:0] fwd_push_be;
	assign head_addr = fifo_out[FIFO_W-1 -: ADDR_W];
	assign head_be = fifo_out[WORD_W +: 4];
	assign head_word = fifo_out[WORD_W-1:0];

	// lanes of pending writes that a read captured now must see;
	// the head drains and the newest write is pushed on this same
	// edge, so neither is in the array yet. all-high folds nothing
	always @* begin
		fwd_head_be = 4'hf;
		fwd_push_be = 4'hf;
		if (fifo_out_valid && head_addr == p_addr_ff[0]) begin
			fwd_head_be = head_be; // older write, drains now
		end
		if (wr_push && p_addr_ff[1] == p_addr_ff[0]) begin
			fwd_push_be = p_be_ff[1]; // newer write, pushed now
		end
	end

	// drain into the array; array held while asleep
	always @(posedge clk) begin
		if (fifo_out_valid && !sleep_s) begin
			array_ff[head_addr] <= merge_lanes(array_ff[head_addr], head_word, head_be);
		end
	end

	// read word captured one stage early, pending writes folded in oldest first
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_word_ff <= {WORD_W{1'b0}};
		end else if (go && p_cyc_ff[0] == `SP_CYC_READ) begin
			rd_word_ff <= merge_lanes(merge_lanes(array_ff[p_addr_ff[0]], head_word, fwd_head_be),
				wr_word, fwd_push_be);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	integer j;
	reg nxt_data_oe;
	// driver enable for the word being presented: off while asleep or
	// with the output enable high, else on only when the word leaving
	// the pipe belongs to a read, in step with lane_data_out
	always @* begin
		nxt_data_oe = lane_data_oe;
		if (sleep_s || oe_n_s) begin
			nxt_data_oe = 1'b0;
		end else if (go) begin
			nxt_data_oe = (p_cyc_ff[1] == `SP_CYC_READ);
		end
		// no else: a stalled edge keeps the bus as it was
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lane_data_out <= {(4*LANE_W){1'b0}};
			lane_parity_out <= 4'h0;
			lane_data_oe <= 1'b0;
			sleeping <= 1'b0;
			write_stall <= 1'b0;
		end else begin
			sleeping <= sleep_s;
			write_stall <= !fifo_in_ready;
			if (go) begin
				for (j = 0; j < 4; j = j + 1) begin
					lane_data_out[j*LANE_W +: LANE_W] <= rd_word_ff[j*LW +: LANE_W];
					lane_parity_out[j] <= PARITY ? rd_word_ff[j*LW+LANE_W] : 1'b0;
				end
			end
			lane_data_oe <= nxt_data_oe;
		end
	end
endmodule // sync_burst_sram_port

// ---- tb/sram_port_props.sv ----
/* assertions on the pins of the sram port.
   assumes a bind onto the port's top module. */
`timescale 1ns/1ps
module sram_port_props #(
	parameter LANE_W = 8
) (
	input wire clk,
	input wire arst_n,
	input wire chip_select_n,
	input wire chip_select_b_n,
	input wire chip_select_hi,
	input wire load_or_advance_n,
	input wire read_write_n,
	input wire stall_n_enable,
	input wire output_enable_n,
	input wire sleep_request,
	input wire [4*LANE_W-1:0] lane_data_out,
	input wire [3:0] lane_parity_out,
	input wire lane_data_oe,
	input wire sleeping
);
	// ----------------
	// helpers
	// ----------------
	reg [3:0] lo_cnt_ff;
	wire go = !stall_n_enable && !sleeping;
	wire sel = !chip_select_n && !chip_select_b_n && chip_select_hi;
	wire ld = go && !load_or_advance_n;
	// cycles with output enable held low
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			lo_cnt_ff <= 4'h0;
		else if (output_enable_n)
			lo_cnt_ff <= 4'h0;
		else if (lo_cnt_ff != 4'hf)
			lo_cnt_ff <= lo_cnt_ff + 4'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence two_go;
		go ##1 go;
	endsequence
	// ----------------
	// properties
	// ----------------
	write_oe_off_a: assert property (ld && sel && !read_write_n ##1 two_go |=> !lane_data_oe)
		else $error("drivers on in write");
	read_oe_on_a: assert property (ld && sel && read_write_n && lo_cnt_ff > 4'h6 ##1 two_go |=> lane_data_oe)
		else $error("drivers off in read");
	deselect_off_a: assert property (ld && !sel ##1 two_go |=> !lane_data_oe)
		else $error("drivers on when deselected");
	cont_deselect_a: assert property (ld && !sel ##1 (go && load_or_advance_n) ##1 two_go |=> !lane_data_oe)
		else $error("continue deselect drives");
	stall_hold_a: assert property (stall_n_enable && !sleeping |=> $stable(lane_data_out) && $stable(lane_parity_out))
		else $error("output moved on stall");
	sleep_enter_a: assert property (sleep_request [*8] |=> sleeping)
		else $error("sleep not entered");
	sleep_leave_a: assert property (!sleep_request [*8] |=> !sleeping)
		else $error("sleep not left");
	oe_pin_off_a: assert property (output_enable_n [*6] |=> !lane_data_oe)
		else $error("drivers on with enable high");
	cover property (ld && sel && read_write_n ##1 two_go);
	cover property (ld && sel && !read_write_n ##1 two_go);
	cover property (stall_n_enable ##1 stall_n_enable);
endmodule // sram_port_props

// ---- tb/mem_ctrl_model.sv ----
/* controller model driving the sram port pins.
   assumes drive is called at most once a cycle. */
`timescale 1ns/1ps
module mem_ctrl_model (
	input wire clk,
	output reg [9:0] a,
	output reg [2:0] cs,
	output reg ld_n,
	output reg rw_n,
	output reg st,
	output reg ord,
	output reg oe_n,
	output reg slp,
	output reg [3:0] be_n,
	output reg [35:0] wd
);
	// ----------------
	// pin driving
	// ----------------
	reg [35:0] dp0, dp1;
	// idle deselect at time zero, order only set between bursts
	initial begin
		{a, cs, ld_n, rw_n, st, ord, oe_n, slp, be_n} = 23'h0154f;
		wd = 36'h0;
		dp0 = 36'h0;
		dp1 = 36'h0;
	end
	// pins set at the falling edge; data trails by two live edges
	task drive(input l, input r, input [2:0] c, input [9:0] ad, input [3:0] b, input [35:0] w, input s);
		begin
			@(negedge clk);
			cs = c;
			ld_n = l;
			rw_n = r;
			a = ad;
			be_n = b;
			st = s;
			if (!s) begin
				wd = dp1;
				dp1 = dp0;
				dp0 = w;
			end
		end
	endtask
endmodule // mem_ctrl_model

// ---- tb/testbench.sv ----
/* self-checking bench of the sram port with a reference model.
   assumes the controller model and checker are compiled first. */
`timescale 1ns/1ps
module testbench;
	// ----------------
	// signals
	// ----------------
	reg clk = 1'b0;
	reg arst_n = 1'b0;
	wire [9:0] a;
	wire [2:0] cs;
	wire [3:0] be_n, lane_parity_out;
	wire [35:0] wd;
	wire [31:0] lane_data_out;
	wire ld_n, rw_n, st, ord, oe_n, slp, lane_data_oe, sleeping, write_stall;
	reg [35:0] mem [0:15];
	reg [51:0] q [$];
	reg [1:0] kind = 2'h0, cnt = 2'h0;
	reg [9:0] base = 10'h0;
	reg [3:0] bem = 4'hf;
	reg ord_v = 1'b1, oe_v = 1'b0, l;
	integer fails = 0, checks = 0, i, j, seed;
	always #2 clk = ~clk;
	mem_ctrl_model i_ctl (.clk, .a, .cs, .ld_n, .rw_n, .st, .ord, .oe_n, .slp, .be_n, .wd);
	sync_burst_sram_port i_dut (.clk, .arst_n, .addr_upper(a[9:2]), .addr_lsb0(a[0]), .addr_lsb1(a[1]),
		.chip_select_n(cs[0]), .chip_select_b_n(cs[1]), .chip_select_hi(cs[2]), .load_or_advance_n(ld_n),
		.read_write_n(rw_n), .stall_n_enable(st), .burst_order_sel(ord), .output_enable_n(oe_n),
		.sleep_request(slp), .lane_a_wr_n(be_n[0]), .lane_b_wr_n(be_n[1]), .lane_c_wr_n(be_n[2]),
		.lane_d_wr_n(be_n[3]), .lane_a_data_in(wd[7:0]), .lane_b_data_in(wd[15:8]),
		.lane_c_data_in(wd[23:16]), .lane_d_data_in(wd[31:24]), .lane_parity_in(wd[35:32]),
		.lane_data_out, .lane_parity_out, .lane_data_oe, .sleeping, .write_stall);
	// ----------------
	// tasks
	// ----------------
	task err(input string m);
		begin
			$display("[ERR] %0t %s", $time, m);
			fails = fails + 1;
		end
	endtask
	task give_verdict;
		begin
			if (fails == 0 && checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// result of the cycle two live edges back
	task resolve(input [51:0] e);
		reg [35:0] m;
		begin
			m = mem[e[43:40]];
			checks = checks + 1;
			if (write_stall !== 1'b0) err("write fifo full");
			if (e[51:50] == 2'h2) begin
				for (j = 0; j < 4; j = j + 1)
					if (!e[36+j]) begin
						m[8*j +: 8] = e[8*j +: 8];
						m[32+j] = e[32+j];
					end
				mem[e[43:40]] = m;
				if (lane_data_oe !== 1'b0) err("drivers on in write");
			end else if (e[51:50] == 2'h1) begin
				if ({lane_parity_out, lane_data_out} !== m) err("read data");
				if (lane_data_oe !== !oe_n) err("read drivers");
			end else if (lane_data_oe !== 1'b0) err("drivers on when idle");
		end
	endtask
	// one bus cycle plus the model's view of it
	task step(input l, input r, input [2:0] c, input [9:0] ad, input [3:0] b, input s);
		reg [35:0] w;
		reg [9:0] ea;
		begin
			w = {4'($urandom), $urandom};
			i_ctl.drive(l, r, c, ad, b, w, s);
			i_ctl.ord = ord_v;
			i_ctl.oe_n = oe_v;
			if (!s) begin
				if (!l) begin
					kind = (c != 3'h4) ? 2'h0 : (r ? 2'h1 : 2'h2);
					base = ad;
					bem = b;
					cnt = 2'h0;
				end else
					cnt = cnt + 2'h1;
				ea = {base[9:2], ord_v ? base[1:0] ^ cnt : base[1:0] + cnt};
				q.push_back({kind, ea, bem, w});
			end
			@(posedge clk);
			#1;
			if (!s && q.size() > 2)
				resolve(q.pop_front());
		end
	endtask
	task idle(input integer n);
		repeat (n) step(1'b0, 1'b1, 3'h5, 10'h0, 4'hf, 1'b0);
	endtask
	// ----------------
	// tests
	// ----------------
	initial begin
		#40000;
		fails = fails + 1;
		give_verdict;
	end
	initial begin
		seed = $urandom(32'hac02032f);
		repeat (10) @(negedge clk);
		arst_n = 1'b1;
		repeat (8) @(negedge clk);
		// each deselect kind, then a continue that stays idle
		for (i = 0; i < 3; i = i + 1) begin
			step(1'b0, 1'b1, i == 0 ? 3'h5 : (i == 1 ? 3'h6 : 3'h0), 10'h0, 4'hf, 1'b0);
			step(1'b1, 1'b0, 3'h4, 10'h0, 4'h0, 1'b0);
		end
		for (i = 0; i < 16; i = i + 1) step(1'b0, 1'b0, 3'h4, i[9:0], 4'h0, 1'b0);
		// every start in both orders, five beats to see the wrap
		for (i = 0; i < 8; i = i + 1) begin
			idle(2);
			ord_v = i[2];
			step(1'b0, 1'b1, 3'h4, {8'h1, i[1:0]}, 4'hf, 1'b0);
			repeat (4) step(1'b1, 1'b0, 3'h0, 10'h0, 4'h0, 1'b0);
		end
		// random mix of loads, bursts, stalls and deselects
		for (i = 0; i < 400; i = i + 1) begin
			l = ($urandom % 3) != 0;
			step(l, 1'($urandom), ($urandom % 6 == 0) ? 3'h5 : 3'h4, 10'($urandom % 16),
				l ? bem : 4'($urandom), $urandom % 8 == 0);
		end
		oe_v = 1'b1;
		idle(6);
		step(1'b0, 1'b1, 3'h4, 10'h9, 4'hf, 1'b0);
		repeat (3) step(1'b1, 1'b1, 3'h4, 10'h0, 4'hf, 1'b0);
		idle(2);
		oe_v = 1'b0;
		idle(6);
		@(negedge clk);
		i_ctl.slp = 1'b1;
		repeat (10) @(negedge clk);
		checks = checks + 1;
		if (sleeping !== 1'b1) err("no sleep");
		i_ctl.drive(1'b0, 1'b0, 3'h4, 10'h9, 4'h0, 36'h0, 1'b0);
		@(negedge clk);
		i_ctl.cs = 3'h5;
		i_ctl.slp = 1'b0;
		repeat (10) @(negedge clk);
		if (sleeping !== 1'b0) err("no wake");
		idle(2);
		step(1'b0, 1'b1, 3'h4, 10'h9, 4'hf, 1'b0);
		idle(2);
		give_verdict;
	end
endmodule // testbench
bind sync_burst_sram_port sram_port_props #(.LANE_W(LANE_W)) i_props (.clk, .arst_n, .chip_select_n,
	.chip_select_b_n, .chip_select_hi, .load_or_advance_n, .read_write_n, .stall_n_enable, .output_enable_n,
	.sleep_request, .lane_data_out, .lane_parity_out, .lane_data_oe, .sleeping);
